// >>> hdl/fc_credit_defines.svh
// Register offsets, field positions and widths for the VC0 flow control status bank.
// Assumes inclusion by bare name from the design files.
`ifndef FC_CREDIT_DEFINES_SVH
`define FC_CREDIT_DEFINES_SVH

`define CPL_LIMIT_OFFSET      12'h0814
`define PST_ALLOC_OFFSET      12'h0818
`define NPS_ALLOC_OFFSET      12'h081C
`define CPL_ALLOC_OFFSET      12'h0820
`define ADDR_WIDTH            12
`define LIMIT_VALID_BIT       31
`define UNLIM_HDR_BIT         30
`define UNLIM_DAT_BIT         29
`define HDR_MSB               21
`define HDR_LSB               14
`define DAT_MSB               11
`define DAT_LSB               0
`define HDR_WIDTH             8
`define DAT_WIDTH             12
`define ZERO_WORD             32'h0000_0000
`define CREDIT_REG_COUNT      4

`endif

// >>> hdl/fc_credit_pkg.sv
// Types shared by the VC0 flow control status bank.
// Assumes fc_credit_defines.svh is compiled alongside.
`include "fc_credit_defines.svh"
package fc_credit_pkg;
  typedef logic [`HDR_WIDTH-1:0] hdr_credit_t;
  typedef logic [`DAT_WIDTH-1:0] dat_credit_t;
  typedef enum logic [2:0] {
    SEL_NONE      = 3'b000,
    SEL_CPL_LIMIT = 3'b001,
    SEL_PST_ALLOC = 3'b011,
    SEL_NPS_ALLOC = 3'b010,
    SEL_CPL_ALLOC = 3'b110
  } reg_sel_t;
endpackage

// >>> hdl/credit_field_pack.sv
// Packs a header and data credit count into the common register layout.
// Assumes counts are already registered by the caller.
`include "fc_credit_defines.svh"
module credit_field_pack (
  input  wire fc_credit_pkg::hdr_credit_t header_credit_count_i,
  input  wire fc_credit_pkg::dat_credit_t data_credit_count_i,
  output logic [31:0]                     word_o
);
  always_comb begin
    word_o                          = `ZERO_WORD;
    word_o[`HDR_MSB:`HDR_LSB]       = header_credit_count_i;
    word_o[`DAT_MSB:`DAT_LSB]       = data_credit_count_i;
  end
endmodule // credit_field_pack

// >>> hdl/apb_addr_decode.sv
// Decodes an APB byte address into one of the bank's registers.
// Assumes word-aligned addresses; low two bits are ignored.
`include "fc_credit_defines.svh"
module apb_addr_decode (
  input  wire logic [`ADDR_WIDTH-1:0] addr_i,
  output fc_credit_pkg::reg_sel_t     sel_o
);
  always_comb begin
    unique case ({addr_i[`ADDR_WIDTH-1:2], 2'b00})
      `CPL_LIMIT_OFFSET: sel_o = fc_credit_pkg::SEL_CPL_LIMIT;
      `PST_ALLOC_OFFSET: sel_o = fc_credit_pkg::SEL_PST_ALLOC;
      `NPS_ALLOC_OFFSET: sel_o = fc_credit_pkg::SEL_NPS_ALLOC;
      `CPL_ALLOC_OFFSET: sel_o = fc_credit_pkg::SEL_CPL_ALLOC;
      default:           sel_o = fc_credit_pkg::SEL_NONE;
    endcase
  end
endmodule // apb_addr_decode

// >>> hdl/fc_credit_status.sv
// VC0 flow control credit status bank, read over APB.
// Assumes the link layer presents credit state synchronous to CLK_SYS_I.
//
// Overview of operation
// - Limit valid bit 31 sets once partner initial flow control arrives.
// - Bit 30 shows partner advertised unlimited completion header credits.
// - Bit 29 shows partner advertised unlimited completion data credits.
// - Count field is undefined while its unlimited flag is set.
// - Completion limit header count at 21:14, data count at 11:0.
// - Posted allocated header count at 21:14, data count at 11:0.
// - Non-posted allocated header count at 21:14, data count at 11:0.
// - Completion allocated header count at 21:14, data count at 11:0.
`include "fc_credit_defines.svh"
module fc_credit_status (
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        RESET_N_I,
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [`ADDR_WIDTH-1:0]      PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  output logic      [31:0]                 PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  input  wire logic                        INIT_FC_RECEIVED_I,
  input  wire logic                        CPL_UNLIM_HDR_I,
  input  wire logic                        CPL_UNLIM_DAT_I,
  input  wire fc_credit_pkg::hdr_credit_t  CPL_LIMIT_HDR_I,
  input  wire fc_credit_pkg::dat_credit_t  CPL_LIMIT_DAT_I,
  input  wire fc_credit_pkg::hdr_credit_t  PST_ALLOC_HDR_I,
  input  wire fc_credit_pkg::dat_credit_t  PST_ALLOC_DAT_I,
  input  wire fc_credit_pkg::hdr_credit_t  NPS_ALLOC_HDR_I,
  input  wire fc_credit_pkg::dat_credit_t  NPS_ALLOC_DAT_I,
  input  wire fc_credit_pkg::hdr_credit_t  CPL_ALLOC_HDR_I,
  input  wire fc_credit_pkg::dat_credit_t  CPL_ALLOC_DAT_I
);

  logic                        limit_valid_reg;
  logic                        unlimited_header_credit_flag_reg;
  logic                        unlimited_data_credit_flag_reg;
  fc_credit_pkg::hdr_credit_t  cpl_lim_hdr_reg;
  fc_credit_pkg::dat_credit_t  cpl_lim_dat_reg;
  fc_credit_pkg::hdr_credit_t  pst_hdr_reg;
  fc_credit_pkg::dat_credit_t  pst_dat_reg;
  fc_credit_pkg::hdr_credit_t  nps_hdr_reg;
  fc_credit_pkg::dat_credit_t  nps_dat_reg;
  fc_credit_pkg::hdr_credit_t  cpl_hdr_reg;
  fc_credit_pkg::dat_credit_t  cpl_dat_reg;
  fc_credit_pkg::hdr_credit_t  hdr_bank [`CREDIT_REG_COUNT];
  fc_credit_pkg::dat_credit_t  dat_bank [`CREDIT_REG_COUNT];
  logic [31:0]                 word_bank [`CREDIT_REG_COUNT];
  logic [31:0]                 limit_word;
  logic [31:0]                 rdata_next;
  logic                        setup_phase;
  logic                        read_setup;
  logic                        first_init;
  logic                        unmapped;
  logic                        pslverr_next;
  fc_credit_pkg::reg_sel_t     sel;

  // Slot order follows the address map
  localparam int unsigned SLOT_CPL_LIM = 0;
  localparam int unsigned SLOT_PST     = 1;
  localparam int unsigned SLOT_NPS     = 2;
  localparam int unsigned SLOT_CPL     = 3;

  // Valid flag is sticky until reset: limits do not change after init
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      limit_valid_reg <= 1'b0;
    end else if (INIT_FC_RECEIVED_I) begin
      limit_valid_reg <= 1'b1;
    end
  end

  // Only the first init after reset carries limits; repeats are ignored
  assign first_init = INIT_FC_RECEIVED_I && !limit_valid_reg;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      unlimited_header_credit_flag_reg <= 1'b0;
    end else if (first_init) begin
      unlimited_header_credit_flag_reg <= CPL_UNLIM_HDR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      unlimited_data_credit_flag_reg <= 1'b0;
    end else if (first_init) begin
      unlimited_data_credit_flag_reg <= CPL_UNLIM_DAT_I;
    end
  end

  // Counts kept as advertised even when unlimited; software must ignore them then
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cpl_lim_hdr_reg <= '0;
    end else if (first_init) begin
      cpl_lim_hdr_reg <= CPL_LIMIT_HDR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cpl_lim_dat_reg <= '0;
    end else if (first_init) begin
      cpl_lim_dat_reg <= CPL_LIMIT_DAT_I;
    end
  end

  // Allocated counts track the link layer every cycle, one cycle late
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pst_hdr_reg <= '0;
    end else begin
      pst_hdr_reg <= PST_ALLOC_HDR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pst_dat_reg <= '0;
    end else begin
      pst_dat_reg <= PST_ALLOC_DAT_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nps_hdr_reg <= '0;
    end else begin
      nps_hdr_reg <= NPS_ALLOC_HDR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nps_dat_reg <= '0;
    end else begin
      nps_dat_reg <= NPS_ALLOC_DAT_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cpl_hdr_reg <= '0;
    end else begin
      cpl_hdr_reg <= CPL_ALLOC_HDR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cpl_dat_reg <= '0;
    end else begin
      cpl_dat_reg <= CPL_ALLOC_DAT_I;
    end
  end

  assign hdr_bank[SLOT_CPL_LIM] = cpl_lim_hdr_reg;
  assign dat_bank[SLOT_CPL_LIM] = cpl_lim_dat_reg;
  assign hdr_bank[SLOT_PST]     = pst_hdr_reg;
  assign dat_bank[SLOT_PST]     = pst_dat_reg;
  assign hdr_bank[SLOT_NPS]     = nps_hdr_reg;
  assign dat_bank[SLOT_NPS]     = nps_dat_reg;
  assign hdr_bank[SLOT_CPL]     = cpl_hdr_reg;
  assign dat_bank[SLOT_CPL]     = cpl_dat_reg;

  genvar slot;
  generate
    for (slot = 0; slot < `CREDIT_REG_COUNT; slot = slot + 1) begin : g_pack
      credit_field_pack u_pack (
        .header_credit_count_i (hdr_bank[slot]),
        .data_credit_count_i   (dat_bank[slot]),
        .word_o                (word_bank[slot])
      );
    end
  endgenerate

  apb_addr_decode u_decode (
    .addr_i (PADDR_I),
    .sel_o  (sel)
  );

  assign setup_phase  = PSEL_I && !PENABLE_I;
  assign read_setup   = setup_phase && !PWRITE_I;
  assign unmapped     = (sel == fc_credit_pkg::SEL_NONE);
  // Writes refused outright: every field mirrors link state, not software state
  assign pslverr_next = setup_phase && (PWRITE_I || unmapped);

  // Flags overlay the packed limit counts; the packer leaves the top bits clear
  always_comb begin
    limit_word                   = word_bank[SLOT_CPL_LIM];
    limit_word[`LIMIT_VALID_BIT] = limit_valid_reg;
    limit_word[`UNLIM_HDR_BIT]   = unlimited_header_credit_flag_reg;
    limit_word[`UNLIM_DAT_BIT]   = unlimited_data_credit_flag_reg;
  end

  always_comb begin
    rdata_next = `ZERO_WORD;
    unique case (sel)
      fc_credit_pkg::SEL_CPL_LIMIT: rdata_next = limit_word;
      fc_credit_pkg::SEL_PST_ALLOC: rdata_next = word_bank[SLOT_PST];
      fc_credit_pkg::SEL_NPS_ALLOC: rdata_next = word_bank[SLOT_NPS];
      fc_credit_pkg::SEL_CPL_ALLOC: rdata_next = word_bank[SLOT_CPL];
      fc_credit_pkg::SEL_NONE:      rdata_next = `ZERO_WORD;
    endcase
  end

  // Read data latched in setup so the access phase completes in one cycle
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PRDATA_O <= `ZERO_WORD;
    end else if (read_setup) begin
      PRDATA_O <= rdata_next;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= setup_phase;
    end
  end

  // Writes never touch state; unmapped addresses and writes get an error
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= pslverr_next;
    end
  end

endmodule // fc_credit_status

// >>> tb/fc_credit_status_monitor.sv
// Checker for the credit status bank, on its top-level ports only.
// Assumes one clock domain; bound to every bank instance at the foot.
`include "fc_credit_defines.svh"
module fc_credit_status_monitor (
  input wire logic        CLK_SYS_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        INIT_FC_RECEIVED_I,
  input wire logic        CPL_UNLIM_HDR_I,
  input wire logic        CPL_UNLIM_DAT_I,
  input wire logic [7:0]  CPL_LIMIT_HDR_I,
  input wire logic [11:0] CPL_LIMIT_DAT_I
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        seen_reg;
  logic [21:0] cap_reg;
  wire         rd = PREADY_O && !PWRITE_I;
  wire         mapped = PADDR_I inside {[`CPL_LIMIT_OFFSET:`CPL_ALLOC_OFFSET]};
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    if (!RESET_N_I) seen_reg <= 1'b0;
    else if (INIT_FC_RECEIVED_I) seen_reg <= 1'b1;
  // Limits are fixed by the first init only
  always_ff @(posedge CLK_SYS_I)
    if (INIT_FC_RECEIVED_I && !seen_reg)
      cap_reg <= {CPL_UNLIM_HDR_I, CPL_UNLIM_DAT_I, CPL_LIMIT_HDR_I, CPL_LIMIT_DAT_I};
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  sequence setup_s; PSEL_I && !PENABLE_I; endsequence
  // Three edges back keeps clear of the capture edge
  property lim_p(ok);
    rd && PADDR_I == `CPL_LIMIT_OFFSET && $past(seen_reg, 3) |-> ok;
  endproperty
  AST_RDY: assert property (setup_s |=> PREADY_O) else $error("no ready after setup");
  AST_PULSE: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
  AST_WR_ERR: assert property (PREADY_O && PWRITE_I |-> PSLVERR_O) else $error("write ok");
  AST_RD_OK: assert property (rd && mapped |-> !PSLVERR_O) else $error("read refused");
  AST_RSV: assert property (rd |-> !PRDATA_O[28:22] && !PRDATA_O[13:12]) else $error("rsv");
  AST_VALID: assert property (lim_p(PRDATA_O[31])) else $error("valid clear");
  AST_UNLIM: assert property (lim_p(PRDATA_O[30:29] == cap_reg[21:20])) else $error("flags");
  AST_LIMIT: assert property (lim_p((cap_reg[21] || PRDATA_O[21:14] == cap_reg[19:12])
    && (cap_reg[20] || PRDATA_O[11:0] == cap_reg[11:0]))) else $error("limit counts");
endmodule // fc_credit_status_monitor

bind fc_credit_status fc_credit_status_monitor fc_credit_status_monitor_inst (.*);

// >>> tb/link_partner_model.sv
// Link partner model: advertises completion limits, drives allocated counts.
// Assumes the bench steps init_i and bump_i just after rising clk_i edges.
module link_partner_model (
  input  wire logic       clk_i,
  input  wire logic       init_i,
  input  wire logic       bump_i,
  input  wire logic [1:0] unlim_i,
  output logic            init_fc_o,
  output logic [1:0]      unlim_o,
  output logic [19:0]     limit_o,
  output logic [59:0]     alloc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {init_fc_o, unlim_o, limit_o, alloc_o} = '0;
  // Repeated init packets carry the same limits
  always @(posedge clk_i) begin
    if (init_i && !init_fc_o) {unlim_o, limit_o} <= {unlim_i, 20'($urandom)};
    if (bump_i) alloc_o <= 60'({$urandom, $urandom});
    init_fc_o <= init_i;
  end
endmodule // link_partner_model

// >>> tb/tb.sv
// Bench for the credit status bank: APB traffic checked against a model.
// Assumes the bound checker and the link partner model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = '0, rst_n = '0, psel = '0, pen = '0, pwr = '0, go = '0, bump = '0;
  logic        v, pready, perr, ifc;
  logic [1:0]  uq = '0, unl;
  logic [11:0] paddr = '0;
  logic [11:0] adr [$] = '{12'h814, 12'h818, 12'h81C, 12'h820, 12'h824, 12'h810};
  logic [19:0] lim;
  logic [31:0] pwdata = '0, prdata, x;
  logic [59:0] al;
  int          bad_count = 0, n_tests = 0;
  initial forever #20 clk = ~clk;
  link_partner_model link_partner_model_inst (.clk_i(clk), .init_i(go), .bump_i(bump),
    .unlim_i(uq), .init_fc_o(ifc), .unlim_o(unl), .limit_o(lim), .alloc_o(al));
  fc_credit_status fc_credit_status_inst (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(perr), .INIT_FC_RECEIVED_I(ifc), .CPL_UNLIM_HDR_I(unl[1]),
    .CPL_UNLIM_DAT_I(unl[0]), .CPL_LIMIT_HDR_I(lim[19:12]), .CPL_LIMIT_DAT_I(lim[11:0]),
    .PST_ALLOC_HDR_I(al[59:52]), .PST_ALLOC_DAT_I(al[51:40]), .NPS_ALLOC_HDR_I(al[39:32]),
    .NPS_ALLOC_DAT_I(al[31:20]), .CPL_ALLOC_HDR_I(al[19:12]), .CPL_ALLOC_DAT_I(al[11:0]));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Limit counts mean nothing before valid or under their unlimited flag
  task automatic acc(input logic w, input logic [11:0] a);
    int          t;
    logic [19:0] f;
    logic [31:0] m;
    logic        l, ok;
    t = 0;
    f = a == 12'h814 ? lim : 20'(al >> (40 - 20 * ((a - 12'h818) >> 2)));
    ok = a inside {[12'h814:12'h820]};
    l = v && a == 12'h814;
    m = a == 12'h814 ? {10'h3FF, {8{v && !unl[1]}}, 2'h3, {12{v && !unl[0]}}} : 32'hFFFF_FFFF;
    x = ok ? {l, unl & {2{l}}, 7'h0, f[19:12], 2'h0, f[11:0]} : '0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= $urandom;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk) t++; while (pready !== 1'b1 && t < 50);
    pen <= 1'b0;
    if (t >= 50) bad_count++;
    if (!w) chk("prdata", x & m, prdata & m);
    chk("pslverr", {31'h0, w || !ok}, {31'h0, perr});
  endtask
  initial begin
    void'($urandom(15));
    for (int k = 0; k < 4; k++) begin
      rst_n <= 1'b0;
      v = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      uq <= 2'(k);
      @(posedge clk);
      acc(1'b0, 12'h814);
      psel <= 1'b0;
      go <= 1'b1;
      repeat (3) @(posedge clk);
      {go, bump} <= 2'b01;
      @(posedge clk);
      bump <= 1'b0;
      v = 1'b1;
      repeat (3) @(posedge clk);
      for (int p = 0; p < 18; p++) acc(p / 6 == 1, adr[p % 6]);
      psel <= 1'b0;
      $display("test %0d done", k);
    end
    @(posedge clk);
    complete_run;
  end
  // About eleven times the expected length of the run
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule // tb
